/* File: rtl/led_cfg_defines.svh */
// Operation
// - drivers one and two take a 3-bit edge rate from bits 6:4, reset 0
// - drivers one and two take a 4-bit coarse code from bits 3:0, reset 0
// - peak current is coarse value times fine multiplier times strength factor
// - shared register holds three 5-bit fine codes at 15:11, 10:6, 4:0, reset 0xC
// - driver two strength bit 13 resets to 1; 0 selects low-power mode
// - slot A pulse width sits in bits 12:8, 1 us steps, reset 0x3
`ifndef LED_CFG_DEFINES_SVH
`define LED_CFG_DEFINES_SVH
`define ADDR_DRV_TWO 8'h24
`define ADDR_FINE 8'h25
`define ADDR_SLOT_A 8'h30
`define ADDR_DRV_ONE 8'h23
`define EDGE_HI 6
`define EDGE_LO 4
`define COARSE_HI 3
`define COARSE_LO 0
`define STRENGTH_BIT 13
`define KEEP_ONE_BIT 12
`define FINE_RSVD_BIT 5
`define FINE_THREE_HI 15
`define FINE_THREE_LO 11
`define FINE_TWO_HI 10
`define FINE_TWO_LO 6
`define FINE_ONE_HI 4
`define FINE_ONE_LO 0
`define WIDTH_HI 12
`define WIDTH_LO 8
`define DRV_RESET 16'h3000
`define FINE_RESET 16'h630c
`define SLOT_A_RESET 16'h0300
`define DRV_WMASK 16'h207f
`define FINE_WMASK 16'hffdf
`define SLOT_A_WMASK 16'h1fff
`define WIDTH_RESET 5'h03
`define FINE_CODE_RESET 5'h0c
`define EDGE_RESET 3'h0
`define COARSE_RESET 4'h0
`define STRENGTH_RESET 1'b1
`endif

/* File: rtl/led_cfg_pkg.sv */
package led_cfg_pkg;
  typedef struct packed {
    logic [2:0] edge_rate;
    logic [3:0] coarse_code;
    logic strength_bit;
    logic [4:0] fine_code;
  } drv_cfg_s;
endpackage

/* File: rtl/led_drive_current_config_regs.sv */
`timescale 1ns/1ps
`include "led_cfg_defines.svh"
module led_drive_current_config_regs
  import led_cfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wr_en_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] rdata_out,
  output drv_cfg_s drv_one_out,
  output drv_cfg_s drv_two_out,
  output logic [4:0] drv_three_fine_code_out,
  output logic [4:0] first_slot_pulse_width_out
);
  logic [15:0] led_one_drive_config;
  logic [15:0] led_two_drive_config;
  logic [15:0] led_fine_adjust;
  logic [15:0] slot_a_pulse_width;

  // masked writes keep unimplemented bits at their documented values,
  // so a careless host cannot corrupt reserved fields
  function automatic logic [15:0] merge(input logic [15:0] d, input logic [15:0] m, input logic [15:0] r);
    merge = (d & m) | (r & ~m);
  endfunction

  // one compare per register, shared by the write strobes and the read mux
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
    addr_is = (a == r);
  endfunction

  wire sel_one = addr_is(addr_in, `ADDR_DRV_ONE);
  wire sel_two = addr_is(addr_in, `ADDR_DRV_TWO);
  wire sel_fine = addr_is(addr_in, `ADDR_FINE);
  wire sel_slot = addr_is(addr_in, `ADDR_SLOT_A);
  // unmapped addresses read as zero and swallow writes
  wire sel_none = !(sel_one || sel_two || sel_fine || sel_slot);
  wire hit_one = wr_en_in && sel_one;
  wire hit_two = wr_en_in && sel_two;
  wire hit_fine = wr_en_in && sel_fine;
  wire hit_slot = wr_en_in && sel_slot;
  wire hit_none = wr_en_in && sel_none;
  wire [15:0] next_one = merge(wdata_in, `DRV_WMASK, `DRV_RESET);
  wire [15:0] next_two = merge(wdata_in, `DRV_WMASK, `DRV_RESET);
  wire [15:0] next_fine = merge(wdata_in, `FINE_WMASK, 16'h0000);
  wire [15:0] next_slot = merge(wdata_in, `SLOT_A_WMASK, 16'h0000);
  logic [15:0] next_rdata;
  assign next_rdata = sel_one ? led_one_drive_config :
                      sel_two ? led_two_drive_config :
                      sel_fine ? led_fine_adjust :
                      sel_slot ? slot_a_pulse_width : 16'h0000;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      led_one_drive_config <= `DRV_RESET;
    end else if (hit_one) begin
      led_one_drive_config <= next_one;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      led_two_drive_config <= `DRV_RESET;
    end else if (hit_two) begin
      led_two_drive_config <= next_two;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      led_fine_adjust <= `FINE_RESET;
    end else if (hit_fine) begin
      led_fine_adjust <= next_fine;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      slot_a_pulse_width <= `SLOT_A_RESET;
    end else if (hit_slot) begin
      slot_a_pulse_width <= next_slot;
    end
  end

  // every output is a flop of its own, loaded one edge after its register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      drv_one_out <= '{`EDGE_RESET, `COARSE_RESET, `STRENGTH_RESET, `FINE_CODE_RESET};
    end else begin
      drv_one_out.edge_rate <= led_one_drive_config[`EDGE_HI:`EDGE_LO];
      drv_one_out.coarse_code <= led_one_drive_config[`COARSE_HI:`COARSE_LO];
      drv_one_out.strength_bit <= led_one_drive_config[`STRENGTH_BIT];
      drv_one_out.fine_code <= led_fine_adjust[`FINE_ONE_HI:`FINE_ONE_LO];
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      drv_two_out <= '{`EDGE_RESET, `COARSE_RESET, `STRENGTH_RESET, `FINE_CODE_RESET};
    end else begin
      drv_two_out.edge_rate <= led_two_drive_config[`EDGE_HI:`EDGE_LO];
      drv_two_out.coarse_code <= led_two_drive_config[`COARSE_HI:`COARSE_LO];
      drv_two_out.strength_bit <= led_two_drive_config[`STRENGTH_BIT];
      drv_two_out.fine_code <= led_fine_adjust[`FINE_TWO_HI:`FINE_TWO_LO];
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      drv_three_fine_code_out <= `FINE_CODE_RESET;
    end else begin
      drv_three_fine_code_out <= led_fine_adjust[`FINE_THREE_HI:`FINE_THREE_LO];
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      first_slot_pulse_width_out <= `WIDTH_RESET;
    end else begin
      first_slot_pulse_width_out <= slot_a_pulse_width[`WIDTH_HI:`WIDTH_LO];
    end
  end

  // the analog sink forms coarse x fine x strength; coarse and strength share a register and
  // switch on the same edge, while the fine code follows the fine register and switches on its own write

  a_edge_follows: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_two |=> ##1 drv_two_out.edge_rate == $past(wdata_in[`EDGE_HI:`EDGE_LO], 2))
    else $error("edge rate not applied");
  a_coarse_follows: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_one |=> ##1 drv_one_out.coarse_code == $past(wdata_in[`COARSE_HI:`COARSE_LO], 2))
    else $error("coarse code not applied");
  a_factor_set: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_one |=> ##1 drv_one_out.strength_bit == $past(wdata_in[`STRENGTH_BIT], 2))
    else $error("strength factor not applied");
  a_fine_three: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_fine |=> ##1 drv_three_fine_code_out == $past(wdata_in[`FINE_THREE_HI:`FINE_THREE_LO], 2))
    else $error("fine code three wrong");
  a_fine_reserved: assert property (@(posedge clk_in) disable iff (reset_in)
    led_fine_adjust[`FINE_RSVD_BIT] == 1'b0)
    else $error("fine reserved bit set");
  a_strength_two: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_two |=> ##1 drv_two_out.strength_bit == $past(wdata_in[`STRENGTH_BIT], 2))
    else $error("strength bit two wrong");
  a_width_follows: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_slot |=> ##1 first_slot_pulse_width_out == $past(wdata_in[`WIDTH_HI:`WIDTH_LO], 2))
    else $error("pulse width not applied");
  a_keep_one: assert property (@(posedge clk_in) disable iff (reset_in)
    led_two_drive_config[`KEEP_ONE_BIT] && led_one_drive_config[`KEEP_ONE_BIT])
    else $error("reserved one bit cleared");
  a_read_back: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_slot ##1 addr_in == `ADDR_SLOT_A && !wr_en_in |=> rdata_out == $past(next_slot, 2))
    else $error("read back mismatch");
  a_edge_one: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_one |=> ##1 drv_one_out.edge_rate == $past(wdata_in[`EDGE_HI:`EDGE_LO], 2))
    else $error("edge rate one not applied");
  a_coarse_two: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_two |=> ##1 drv_two_out.coarse_code == $past(wdata_in[`COARSE_HI:`COARSE_LO], 2))
    else $error("coarse code two not applied");
  a_fine_one: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_fine |=> ##1 drv_one_out.fine_code == $past(wdata_in[`FINE_ONE_HI:`FINE_ONE_LO], 2))
    else $error("fine code one wrong");
  a_fine_two: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_fine |=> ##1 drv_two_out.fine_code == $past(wdata_in[`FINE_TWO_HI:`FINE_TWO_LO], 2))
    else $error("fine code two wrong");
  // reserved bits never move, whatever the host sends
  a_one_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    (led_one_drive_config & ~`DRV_WMASK) == (`DRV_RESET & ~`DRV_WMASK))
    else $error("driver one reserved bits moved");
  a_two_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    (led_two_drive_config & ~`DRV_WMASK) == (`DRV_RESET & ~`DRV_WMASK))
    else $error("driver two reserved bits moved");
  a_fine_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    (led_fine_adjust & ~`FINE_WMASK) == 16'h0000)
    else $error("fine reserved bits moved");
  a_slot_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    (slot_a_pulse_width & ~`SLOT_A_WMASK) == 16'h0000)
    else $error("slot reserved bits moved");
  a_stray_write: assert property (@(posedge clk_in) disable iff (reset_in)
    hit_none |=> $stable(led_one_drive_config) && $stable(led_two_drive_config) &&
      $stable(led_fine_adjust) && $stable(slot_a_pulse_width))
    else $error("unmapped write changed a register");
  // read data is the register as it stood at the address edge
  a_read_one: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_one |=> rdata_out == $past(led_one_drive_config))
    else $error("driver one read wrong");
  a_read_two: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_two |=> rdata_out == $past(led_two_drive_config))
    else $error("driver two read wrong");
  a_read_fine: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_fine |=> rdata_out == $past(led_fine_adjust))
    else $error("fine read wrong");
  a_read_slot: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_slot |=> rdata_out == $past(slot_a_pulse_width))
    else $error("slot read wrong");
  a_read_none: assert property (@(posedge clk_in) disable iff (reset_in)
    sel_none |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_one_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    !hit_one |=> $stable(led_one_drive_config))
    else $error("driver one changed without write");
  a_two_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    !hit_two |=> $stable(led_two_drive_config))
    else $error("driver two changed without write");
  a_fine_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    !hit_fine |=> $stable(led_fine_adjust))
    else $error("fine changed without write");
  a_slot_holds: assert property (@(posedge clk_in) disable iff (reset_in)
    !hit_slot |=> $stable(slot_a_pulse_width))
    else $error("slot changed without write");
  c_stray_write: cover property (@(posedge clk_in) disable iff (reset_in) hit_none);
  c_write_two: cover property (@(posedge clk_in) disable iff (reset_in) hit_two);
  c_low_power: cover property (@(posedge clk_in) disable iff (reset_in) !drv_two_out.strength_bit);
  c_fine_write: cover property (@(posedge clk_in) disable iff (reset_in) hit_fine);
  c_width_max: cover property (@(posedge clk_in) disable iff (reset_in) first_slot_pulse_width_out == 5'h1f);
endmodule // led_drive_current_config_regs

/* File: dv/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input wire logic clk_in,
  output logic wr_en_out = 1'b0,
  output logic [7:0] addr_out = 8'h00,
  output logic [15:0] wdata_out = 16'h0000
);
  function automatic logic [15:0] fix(input logic [7:0] a, input logic [15:0] d);
    return (a == 8'h23 || a == 8'h24) ? (d & 16'h207f) | 16'h1000 :
      a == 8'h25 ? d & 16'hffdf : a == 8'h30 ? d & 16'h1fff : d;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in) #1 {wr_en_out, addr_out, wdata_out} = {1'b1, a, fix(a, d)};
    @(posedge clk_in) #1 {wr_en_out, wdata_out} = {1'b0, ~wdata_out}; // stale data would hide a missed strobe
  endtask
  task automatic point(input logic [7:0] a);
    @(posedge clk_in) #1 addr_out = a;
    @(posedge clk_in) #1;
  endtask
endmodule // host_model

/* File: dv/led_drive_current_config_regs_tb_top.sv */
`timescale 1ns/1ps
module led_drive_current_config_regs_tb_top;
  import led_cfg_pkg::*;
  logic clk_in = 1'b0, reset_in, wr_en;
  logic [7:0] addr, a, al [5] = '{8'h23, 8'h24, 8'h25, 8'h30, 8'h26};
  logic [15:0] wdata, rdata, d;
  drv_cfg_s one, two;
  logic [4:0] fine3, width;
  int n_mismatch = 0, n_tests = 0;
  logic [15:0] m [logic [7:0]];
  host_model host_model_inst (.clk_in(clk_in), .wr_en_out(wr_en), .addr_out(addr), .wdata_out(wdata));
  led_drive_current_config_regs led_drive_current_config_regs_inst (.clk_in(clk_in), .reset_in(reset_in),
    .wr_en_in(wr_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .drv_one_out(one), .drv_two_out(two),
    .drv_three_fine_code_out(fine3), .first_slot_pulse_width_out(width));
  initial forever #5 clk_in = ~clk_in;
  task automatic chk(input logic [39:0] seen, exp);
    n_tests++;
    if (seen !== exp) $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    n_mismatch += int'(seen !== exp);
  endtask
  task automatic chk_all();
    logic [39:0] e;
    foreach (al[i]) begin
      host_model_inst.point(al[i]);
      chk(40'(rdata), 40'(m.exists(al[i]) ? m[al[i]] : 16'h0000));
    end
    e = 40'({m[8'h23][6:0], m[8'h23][13], m[8'h25][4:0], m[8'h24][6:0],
      m[8'h24][13], m[8'h25][10:6], m[8'h25][15:11], m[8'h30][12:8]});
    chk(40'({one, two, fine3, width}), e);
  endtask
  task automatic do_reset();
    reset_in = 1'b1;
    m = '{8'h23: 16'h3000, 8'h24: 16'h3000, 8'h25: 16'h630c, 8'h30: 16'h0300};
    repeat (12) @(posedge clk_in);
    #1 reset_in = 1'b0;
  endtask
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h3b05));
    do_reset();
    for (int k = 0; k < 40; k++) begin // k*17 walks every edge and coarse code across drivers one and two together, even codes to one and odd to two, with strength low
      if (k % 3 != 2) chk_all();
      a = al[k < 16 ? k % 2 : $urandom_range(4, 0)];
      d = k < 16 ? 16'(k * 17) : 16'($urandom);
      host_model_inst.wr(a, d);
      if (a != 8'h26) m[a] = host_model_inst.fix(a, d);
      if (k == 31) do_reset();
    end
    test_done();
  end
  initial begin
    #200000 n_mismatch++;
    test_done();
  end
endmodule // led_drive_current_config_regs_tb_top
